// file: hdl/dacc_top.sv
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module dacc_top #(
	parameter int ANA_W = dacc_pkg::DACC_ANA_W
) (
	input  wire logic                              CORE_CLK_IN,
	input  wire logic                              RESETN_IN,
	// classic wishbone slave
	input  wire logic                              WB_CYC_IN,
	input  wire logic                              WB_STB_IN,
	input  wire logic                              WB_WE_IN,
	input  wire logic [dacc_pkg::DACC_ADDR_W-1:0] WB_ADR_IN,
	input  wire logic                              WB_SEL_IN,
	input  wire logic [7:0]                        WB_DAT_IN,
	output logic      [7:0]                        WB_DAT_OUT,
	output logic                                   WB_ACK_OUT,
	output logic                                   WB_ERR_OUT,
	// power state, informational only
	input  wire logic                              SLEEP_IN,
	// source voltages seen by the ladder
	input  wire logic [ANA_W-1:0]                  AVDD_LVL_IN,
	input  wire logic [ANA_W-1:0]                  VREF_POS_LVL_IN,
	input  wire logic [ANA_W-1:0]                  FIXED_REF_LVL_IN,
	input  wire logic [ANA_W-1:0]                  VREF_NEG_LVL_IN,
	// analog_out_pin_1 digital functions from the port logic
	input  wire logic                              PIN_DRV_OE_IN,
	input  wire logic                              PIN_PULLUP_IN,
	input  wire logic                              PIN_RAW_IN,
	// ladder results and pin control
	output dacc_pkg::dacc_ladder_t                 LADDER_CFG_OUT,
	output logic      [ANA_W-1:0]                  DAC_LEVEL_OUT,
	output logic      [ANA_W-1:0]                  PIN_ANALOG_LVL_OUT,
	output logic                                   PIN_ANALOG_SW_OUT,
	output logic                                   PIN_DRV_OE_OUT,
	output logic                                   PIN_PULLUP_OUT,
	output logic                                   PIN_DETECT_EN_OUT,
	output logic                                   PIN_READ_OUT
);
	import dacc_pkg::*;

	initial begin
		if (ANA_W < 2 || ANA_W > 24) begin
			$error("ANA_W out of range");
		end
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic       req;
	logic       hit_ctl;
	logic       hit_lvl;
	logic       wr_ok;
	logic [7:0] control_r;
	logic [7:0] level_r;
	logic [7:0] rd_nxt;

	// a request is answered once; ack low for the cycle after it fell
	assign req     = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
	assign hit_ctl = (WB_ADR_IN == DACC_CONTROL_ADR);
	assign hit_lvl = (WB_ADR_IN == DACC_LEVEL_ADR);
	assign wr_ok   = req && WB_WE_IN && WB_SEL_IN;

	// unimplemented bits masked so they read zero
	always_comb begin
		rd_nxt = 8'h00;
		if (hit_ctl) begin
			rd_nxt = control_r & DACC_CONTROL_MSK;
		end else if (hit_lvl) begin
			rd_nxt = level_r & DACC_LEVEL_MSK;
		end
	end

	// single-cycle answer: ack or err one edge after the request is seen
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			WB_ACK_OUT <= 1'b0;
			WB_ERR_OUT <= 1'b0;
		end else begin
			WB_ACK_OUT <= req && (hit_ctl || hit_lvl);
			WB_ERR_OUT <= req && !(hit_ctl || hit_lvl);
		end
	end

	// read data latched with the ack
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			WB_DAT_OUT <= 8'h00;
		end else if (req && !WB_WE_IN) begin
			WB_DAT_OUT <= rd_nxt;
		end else begin
			WB_DAT_OUT <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// only the device reset clears them; sleep entry and wake never touch them
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			control_r <= DACC_RESET_VAL;
		end else if (wr_ok && hit_ctl) begin
			control_r <= WB_DAT_IN & DACC_CONTROL_MSK;
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			level_r <= DACC_RESET_VAL;
		end else if (wr_ok && hit_lvl) begin
			level_r <= WB_DAT_IN & DACC_LEVEL_MSK;
		end
	end

	// ------------------------------------------------------------
	// field decode
	// ------------------------------------------------------------
	dacc_ladder_t     cfg;
	logic [ANA_W-1:0] vpos;
	logic [ANA_W-1:0] vneg;
	logic [ANA_W-1:0] tap;
	logic             route;

	// sleep is deliberately not an input to any of this
	always_comb begin
		cfg.enable    = control_r[DACC_EN_BIT];
		cfg.pin_route = control_r[DACC_OE1_BIT];
		cfg.pos_sel   = dacc_pos_t'(control_r[DACC_PSS_HI:DACC_PSS_LO]);
		cfg.neg_ext   = control_r[DACC_NSS_BIT];
		cfg.level     = level_r[DACC_LEVEL_W-1:0];
	end

	// reserved positive code falls to ground; no tap is better than a guess
	always_comb begin
		case (cfg.pos_sel)
			DACC_POS_SUPPLY:    vpos = AVDD_LVL_IN;
			DACC_POS_EXT_REF:   vpos = VREF_POS_LVL_IN;
			DACC_POS_FIXED_REF: vpos = FIXED_REF_LVL_IN;
			default:            vpos = '0;
		endcase
		vneg = cfg.neg_ext ? VREF_NEG_LVL_IN : '0;
	end

	assign route = cfg.pin_route;

	dacc_ladder #(
		.ANA_W(ANA_W)
	) u_ladder (
		.clk_in   (CORE_CLK_IN),
		.resetn_in(RESETN_IN),
		.cfg_in   (cfg),
		.vpos_in  (vpos),
		.vneg_in  (vneg),
		.level_out(tap)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign DAC_LEVEL_OUT = tap; // flop inside the ladder

	// config mirror for the analog macro
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			LADDER_CFG_OUT <= '0;
		end else begin
			LADDER_CFG_OUT <= cfg;
		end
	end

	// pin switch; the voltage follows the tap one cycle on
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			PIN_ANALOG_SW_OUT  <= 1'b0;
			PIN_ANALOG_LVL_OUT <= '0;
		end else begin
			PIN_ANALOG_SW_OUT  <= route;
			PIN_ANALOG_LVL_OUT <= route ? tap : '0;
		end
	end

	// digital functions forced off while routed, whatever the port asks
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			PIN_DRV_OE_OUT    <= 1'b0;
			PIN_PULLUP_OUT    <= 1'b0;
			PIN_DETECT_EN_OUT <= 1'b0;
			PIN_READ_OUT      <= 1'b0;
		end else begin
			PIN_DRV_OE_OUT    <= PIN_DRV_OE_IN && !route;
			PIN_PULLUP_OUT    <= PIN_PULLUP_IN && !route;
			PIN_DETECT_EN_OUT <= !route;
			PIN_READ_OUT      <= PIN_RAW_IN && !route;
		end
	end
endmodule
`default_nettype wire

// file: hdl/dacc_pkg.sv
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package dacc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int          DACC_ADDR_W      = 12;
	localparam logic [11:0] DACC_CONTROL_ADR = 12'hec6;
	localparam logic [11:0] DACC_LEVEL_ADR   = 12'hec7;
	localparam int          DACC_EN_BIT      = 7;
	localparam int          DACC_OE1_BIT     = 5;
	localparam int          DACC_PSS_HI      = 3;
	localparam int          DACC_PSS_LO      = 2;
	localparam int          DACC_NSS_BIT     = 0;
	localparam logic [7:0]  DACC_CONTROL_MSK = 8'had;
	localparam logic [7:0]  DACC_LEVEL_MSK   = 8'h1f;
	localparam logic [7:0]  DACC_RESET_VAL   = 8'h00;
	localparam int          DACC_LEVEL_W     = 5;
	localparam int          DACC_TAPS        = 32;
	localparam int          DACC_ANA_W       = 8;

	// ------------------------------------------------------------
	// source selections
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DACC_POS_SUPPLY,
		DACC_POS_EXT_REF,
		DACC_POS_FIXED_REF,
		DACC_POS_RESERVED
	} dacc_pos_t;

	// analog-side view of the ladder settings
	typedef struct packed {
		logic                    enable;
		logic                    pin_route;
		dacc_pos_t               pos_sel;
		logic                    neg_ext;
		logic [DACC_LEVEL_W-1:0] level;
	} dacc_ladder_t;

	// override applied to the shared pin
	typedef struct packed {
		logic drv_off;
		logic pullup_off;
		logic detect_off;
	} dacc_pin_ovr_t;
endpackage

// file: hdl/dacc_ladder.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural ladder: digital model of the tap voltage, in source units
module dacc_ladder #(
	parameter int ANA_W = dacc_pkg::DACC_ANA_W
) (
	input  wire logic                 clk_in,
	input  wire logic                 resetn_in,
	input  wire dacc_pkg::dacc_ladder_t cfg_in,
	input  wire logic [ANA_W-1:0]     vpos_in,
	input  wire logic [ANA_W-1:0]     vneg_in,
	output logic      [ANA_W-1:0]     level_out
);
	import dacc_pkg::*;

	logic [ANA_W-1:0]              span;
	logic [ANA_W+DACC_LEVEL_W-1:0] prod;

	// ------------------------------------------------------------
	// tap computation
	// ------------------------------------------------------------
	// a reversed span would wrap; clamp so the tap stays at the negative end
	assign span = (vpos_in > vneg_in) ? ANA_W'(vpos_in - vneg_in) : '0;
	assign prod = (ANA_W+DACC_LEVEL_W)'(span * cfg_in.level);

	// registered so the top sees a flop output; disabled ladder sits at zero
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			level_out <= '0;
		end else if (cfg_in.enable) begin
			level_out <= ANA_W'(vneg_in + ANA_W'(prod / DACC_TAPS));
		end else begin
			level_out <= '0;
		end
	end
endmodule
`default_nettype wire

// file: verification/dacc_props.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// bus and pin checks
// ----
module dacc_props import dacc_pkg::*; #(
	parameter int ANA_W = 8
) (
	input wire logic                CORE_CLK_IN,
	input wire logic                RESETN_IN,
	input wire logic                WB_CYC_IN,
	input wire logic                WB_STB_IN,
	input wire logic [DACC_ADDR_W-1:0] WB_ADR_IN,
	input wire logic [7:0]          WB_DAT_OUT,
	input wire logic                WB_ACK_OUT,
	input wire logic                WB_ERR_OUT,
	input wire dacc_ladder_t        LADDER_CFG_OUT,
	input wire logic [ANA_W-1:0]    DAC_LEVEL_OUT,
	input wire logic                PIN_ANALOG_SW_OUT,
	input wire logic                PIN_DRV_OE_OUT,
	input wire logic                PIN_PULLUP_OUT,
	input wire logic                PIN_DETECT_EN_OUT,
	input wire logic                PIN_READ_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// a request is new only while no answer stands
	wire logic req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT;
	wire logic hit = (WB_ADR_IN == DACC_CONTROL_ADR) || (WB_ADR_IN == DACC_LEVEL_ADR);
	a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack held");
	a_ack_answers: assert property (req && hit |=> WB_ACK_OUT && !WB_ERR_OUT) else $error("no ack");
	a_err_unmapped: assert property (req && !hit |=> WB_ERR_OUT && !WB_ACK_OUT) else $error("no err");
	a_read_mask: assert property (WB_ACK_OUT |-> (WB_DAT_OUT & ((WB_ADR_IN == DACC_CONTROL_ADR)
		? 8'h52 : 8'he0)) == 8'h00) else $error("spare bits set");
	a_data_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 8'h00) else $error("data leaks");
	a_pin_drv_off: assert property (PIN_ANALOG_SW_OUT |-> !PIN_DRV_OE_OUT && !PIN_PULLUP_OUT)
		else $error("driver on");
	a_detect_off: assert property (PIN_ANALOG_SW_OUT |-> !PIN_DETECT_EN_OUT) else $error("detect on");
	a_pin_read_zero: assert property (PIN_ANALOG_SW_OUT |-> !PIN_READ_OUT) else $error("read not 0");
	// config mirror and tap flop both lag the register by one edge, so compare in step
	a_dac_off: assert property (!LADDER_CFG_OUT.enable |-> DAC_LEVEL_OUT == '0) else $error("dac on");
endmodule
bind dacc_top dacc_props #(.ANA_W(ANA_W)) i_dacc_props (.*);
`default_nettype wire

// file: verification/tb_dacc_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dacc_top;
	import dacc_pkg::*;
	logic clk, rst_n, cyc, stb, we, sel, slp, drv, pu, raw, e;
	logic [11:0] adr;
	logic [7:0] wd, q, avdd, vpos, vfix, vneg;
	int n_mismatch, comparisons;
	wire logic [7:0] rdat, lvl, plvl;
	wire logic ack, err, sw, doe, dpu, det, prd;
	wire dacc_ladder_t cfg;
	dacc_top #(.ANA_W(8)) i_dacc_top (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc),
		.WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wd),
		.WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .SLEEP_IN(slp),
		.AVDD_LVL_IN(avdd), .VREF_POS_LVL_IN(vpos), .FIXED_REF_LVL_IN(vfix),
		.VREF_NEG_LVL_IN(vneg), .PIN_DRV_OE_IN(drv), .PIN_PULLUP_IN(pu), .PIN_RAW_IN(raw),
		.LADDER_CFG_OUT(cfg), .DAC_LEVEL_OUT(lvl), .PIN_ANALOG_LVL_OUT(plvl),
		.PIN_ANALOG_SW_OUT(sw), .PIN_DRV_OE_OUT(doe), .PIN_PULLUP_OUT(dpu),
		.PIN_DETECT_EN_OUT(det), .PIN_READ_OUT(prd));
	// ----
	// shared tasks
	// ----
	task automatic end_sim;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask
	// classic cycle; bounded wait so a silent slave cannot hang the run
	task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (ack === 1'b1 || err === 1'b1) break;
		end
		if (i == 20) begin
			n_mismatch++;
			end_sim;
		end
		q = rdat; e = err;
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge clk);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_mask;
		wb(1'b0, DACC_CONTROL_ADR, 8'h00); chk(q, 8'h00);
		wb(1'b0, DACC_LEVEL_ADR, 8'h00); chk(q, 8'h00);
		wb(1'b1, DACC_CONTROL_ADR, 8'hff); chk(cfg, 10'b1111100000);
		wb(1'b0, DACC_CONTROL_ADR, 8'h00); chk(q, 8'had);
		wb(1'b1, DACC_LEVEL_ADR, 8'hff);
		wb(1'b0, DACC_LEVEL_ADR, 8'h00); chk(q, 8'h1f);
	endtask
	// every source code with tap 16, then negative reference and disable
	task automatic t_level;
		logic [7:0] ex [5] = '{8'h40, 8'h20, 8'h10, 8'h00, 8'h48};
		wb(1'b1, DACC_LEVEL_ADR, 8'h10);
		for (int p = 0; p < 5; p++) begin
			wb(1'b1, DACC_CONTROL_ADR, (p == 4) ? 8'h81 : (8'h80 | (p[7:0] << 2)));
			repeat (3) @(posedge clk);
			chk(lvl, ex[p]);
		end
		wb(1'b1, DACC_CONTROL_ADR, 8'h00);
		repeat (3) @(posedge clk);
		chk(lvl, 8'h00);
	endtask
	task automatic t_pins;
		drv <= 1'b1; pu <= 1'b1; raw <= 1'b1;
		wb(1'b1, DACC_CONTROL_ADR, 8'ha0);
		repeat (3) @(posedge clk);
		chk({sw, doe, dpu, det, prd}, 5'b10000);
		chk(plvl, 8'h40);
		wb(1'b1, DACC_CONTROL_ADR, 8'h80);
		repeat (3) @(posedge clk);
		chk({sw, doe, dpu, det, prd, plvl}, 13'h0f00);
	endtask
	// sleep must not disturb settings or output
	task automatic t_sleep;
		slp <= 1'b1;
		repeat (20) @(posedge clk);
		chk(lvl, 8'h40);
		slp <= 1'b0;
		wb(1'b0, DACC_CONTROL_ADR, 8'h00); chk(q, 8'h80);
		wb(1'b1, 12'hec5, 8'hff); chk(e, 1'b1);
		// a write without its byte select is acked but must not land
		sel <= 1'b0;
		wb(1'b1, DACC_CONTROL_ADR, 8'h00); chk(e, 1'b0);
		sel <= 1'b1;
		wb(1'b0, DACC_CONTROL_ADR, 8'h00); chk(q, 8'h80);
	endtask
	task automatic t_rst;
		wb(1'b1, DACC_CONTROL_ADR, 8'ha0);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({cfg, sw}, 11'h000);
		wb(1'b0, DACC_LEVEL_ADR, 8'h00); chk(q, 8'h00);
	endtask
	// free-running core clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// main sequence
	initial begin
		{cyc, stb, we, slp, drv, pu, raw} = '0;
		sel = 1'b1; adr = '0; wd = '0; rst_n = 1'b0;
		avdd = 8'h80; vpos = 8'h40; vfix = 8'h20; vneg = 8'h10;
		n_mismatch = 0; comparisons = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_mask; t_level; t_pins; t_sleep; t_rst;
		end_sim;
	end
endmodule
`default_nettype wire
